//--- core/cwg_wait_gen.sv
// Top of the clocked wait state generator
`timescale 1ns/1ps
`include "cwg_consts.svh"
module cwg_wait_gen import cwg_pkg::*;
#(
    parameter int N_STAGES = `CWG_STAGES_DEF  // Hold-off length in clocks
)
(
    input  wire logic i_clk_sys,    // Phase-two system clock, 10 MHz
    input  wire logic i_rst_b,      // Asynchronous reset, active low
    input  wire logic i_sel_b,      // Peripheral select pin, active low
    output wire logic o_wait_b,     // Processor wait line, active low
    output wire logic o_busy        // Hold-off in progress
);
    // ============================================================
    // Select synchroniser and edge detect
    logic       sel_meta_q;
    logic       sel_sync_q;
    logic       sel_prev_q;
    logic       sel_edge;
    cwg_state_t state_q;
    cwg_state_t state_d;
    logic       boot_done_q;
    cwg_chain_if link ();

    // Width of the helper counter that times the wait line
    localparam int CNT_W = $clog2(N_STAGES + 2);
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_cnt_d;

    // Decodes the hold state; shared by the link and the checks
    function automatic logic cwg_is_hold
    (
        input cwg_state_t st  // State to decode
    );
        return (st == CWG_HOLD);
    endfunction : cwg_is_hold

    // Two flops before any logic reads the pin
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sel_meta_q <= 1'b1;
            sel_sync_q <= 1'b1;
            sel_prev_q <= 1'b1;
        end
        else
        begin
            sel_meta_q <= i_sel_b;
            sel_sync_q <= sel_meta_q;
            sel_prev_q <= sel_sync_q;
        end
    end

    // Falling select is the active edge
    assign sel_edge = sel_prev_q & ~sel_sync_q;

    // ============================================================
    // Main flip-flop next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CWG_IDLE:
                if (sel_edge)
                    state_d = CWG_HOLD;
            CWG_HOLD:
                if (!link.tail)
                    state_d = CWG_IDLE;
                // Further edges ignored here
            default:
                state_d = CWG_IDLE;
        endcase
    end

    // Main flip-flop register
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_q <= CWG_IDLE;
        else
            state_q <= state_d;
    end

    // Marks that one clean edge has passed after reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            boot_done_q <= 1'b0;
        else
            boot_done_q <= 1'b1;
    end

    // ============================================================
    // Chain link and outputs
    // A zero at the tail drops the main output at once, as a direct clear would
    assign link.run = cwg_is_hold(state_q) && link.tail;
    assign o_wait_b = ~link.run;
    assign o_busy   = link.run;

    cwg_shift_chain #(
        .N_STAGES (N_STAGES)
    ) cwg_shift_chain_inst (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .chain     (link.chain)
    );

    // ============================================================
    // Checks

    // Cycles with the wait line low; cleared whenever wait is high
    assign low_cnt_d = o_wait_b ? '0 : low_cnt_q + CNT_W'(1);

    // Helper counter, so the hold length need not be unrolled
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            low_cnt_q <= '0;
        else
            low_cnt_q <= low_cnt_d;
    end

    // Idle main flip-flop meets a fresh select edge
    sequence hold_start_s;
        state_q == CWG_IDLE && sel_edge;
    endsequence

    // Last stage has given up its zero while main is still set
    sequence release_s;
        cwg_is_hold(state_q) && !link.tail;
    endsequence

    // Opening cycles of a hold-off: wait low and the tail still full
    sequence hold_body_s;
        (!o_wait_b && link.tail) ##1 link.tail;
    endsequence

    // Main flip-flop back at rest with the chain preset again
    sequence rest_s;
        state_q == CWG_IDLE && link.tail && o_wait_b;
    endsequence

    // Select edge while idle pulls wait low on the next clock
    hold_start_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        hold_start_s |=> !o_wait_b) else $error("wait not driven after select");

    // Start of a hold-off lifts the preset so the first stage takes a zero
    preset_free_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        hold_start_s |=> ##1 !cwg_shift_chain_inst.stage_q[0])
        else $error("preset not released");

    // Wait stands low for exactly the number of stages
    hold_len_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(o_wait_b) |-> (low_cnt_q == CNT_W'(N_STAGES)))
        else $error("hold-off length wrong");

    // Wait never stays low past the chain length
    hold_cap_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !o_wait_b |-> (low_cnt_q < CNT_W'(N_STAGES)))
        else $error("hold-off overran");

    // Zero at the tail releases wait and clears main on the next clock
    hold_end_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        release_s |-> o_wait_b ##1 state_q == CWG_IDLE)
        else $error("wait not released");

    // A hold-off starts only from idle on a fresh edge
    ignore_sel_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(link.run) |-> $past(state_q == CWG_IDLE && sel_edge))
        else $error("hold started without idle edge");

    // Generator is idle once the first clean edge after reset has passed
    boot_idle_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(boot_done_q) |-> o_wait_b && !o_busy) else $error("not idle after reset");

    // After release the chain is preset and main is idle again
    release_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        release_s |=> rest_s) else $error("chain not preset after release");

    // Idle main flip-flop always leaves wait high and busy low
    idle_wait_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state_q == CWG_IDLE |-> o_wait_b && !o_busy) else $error("wait low while idle");

    // Chain keeps its ones at the tail through the opening cycles
    shift_run_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $fell(o_wait_b) |-> hold_body_s)
        else $error("chain emptied early");

    // Tail falling on the clock edge drops the main output in the same cycle
    edge_clk_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $fell(link.tail) |-> !link.run && o_wait_b) else $error("main not cleared on edge");
endmodule : cwg_wait_gen

//--- core/cwg_consts.svh
// Timing and reset constants for the clocked wait state generator
`ifndef CWG_CONSTS_SVH
`define CWG_CONSTS_SVH
// ============================================================
// Chain and reset values
`define CWG_STAGES_DEF      4
`define CWG_MAIN_RST        1'b0
`define CWG_STAGE_PRESET    1'b1
// Clock rate in kHz and period in ns
`define CWG_CLK_KHZ         10000
`define CWG_CLK_NS          100
`endif

//--- core/cwg_pkg.sv
// Types shared by the clocked wait state generator
package cwg_pkg;
    // Generator state as seen from the bus
    typedef enum logic [0:0]
    {
        CWG_IDLE = 1'b0,
        CWG_HOLD = 1'b1
    } cwg_state_t;
endpackage : cwg_pkg

//--- core/cwg_chain_if.sv
// Interface between the main flip-flop and the shift chain
`timescale 1ns/1ps
interface cwg_chain_if;
    logic run;     // Main flip-flop set, chain released from preset
    logic tail;    // Output of the last stage
    modport main  (output run, input tail);
    modport chain (input run, output tail);
endinterface : cwg_chain_if

//--- core/cwg_shift_chain.sv
// Preset shift chain that counts the hold-off length
`timescale 1ns/1ps
`include "cwg_consts.svh"
module cwg_shift_chain import cwg_pkg::*;
#(
    parameter int N_STAGES = `CWG_STAGES_DEF  // Number of hold-off stages
)
(
    input  wire logic   i_clk_sys,  // Phase-two system clock
    input  wire logic   i_rst_b,    // Asynchronous reset, active low
    cwg_chain_if.chain  chain       // Link to the main flip-flop
);
    // ============================================================
    // Stage registers
    logic [N_STAGES-1:0] stage_q;
    logic [N_STAGES-1:0] stage_d;

    // Zero enters stage one; held at preset while idle
    assign stage_d = chain.run ? {stage_q[N_STAGES-2:0], 1'b0}
                               : {N_STAGES{`CWG_STAGE_PRESET}};
    assign chain.tail = stage_q[N_STAGES-1];

    // Chain advances on the chosen phase-two edge
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            stage_q <= {N_STAGES{`CWG_STAGE_PRESET}};
        else
            stage_q <= stage_d;
    end

    // Idle chain always reads all ones
    chain_preset_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !$past(chain.run) |-> &stage_q) else $error("chain not preset");
endmodule : cwg_shift_chain

//--- tb/cwg_cpu_model.sv
// Processor bus model that selects the peripheral and waits out the hold-off
`timescale 1ns/1ps
module cwg_cpu_model
(
    input  wire logic i_clk_sys,  // Phase-two clock
    input  wire logic i_go,       // Start one access
    input  wire logic i_poke,     // Re-strobe select inside the hold-off
    input  wire logic i_wait_b,   // Wait line from the generator
    output logic      o_sel_b,    // Peripheral select, active low
    output logic      o_done,     // Access finished
    output int        o_len       // Cycles seen with wait low
);
    int n;
    // ============================================================
    // Access sequencer: select stays low until wait is seen high, except for the one-cycle high pulse when i_poke is set
    initial
    begin
        o_sel_b = 1'b1;
        o_done  = 1'b0;
        o_len   = 0;
        forever
        begin
            @(posedge i_clk_sys);
            if (i_go)
            begin
                o_done <= 1'b0;
                n = 0;
                @(negedge i_clk_sys);
                o_sel_b <= 1'b0;
                for (int k = 0; k < 40; k++)
                begin
                    @(negedge i_clk_sys);
                    if (!i_wait_b)
                        n++;
                    else if (n > 0)
                        break;
                    if (i_poke && n == 1)
                        o_sel_b <= 1'b1;  // Short high pulse during hold-off
                    if (i_poke && n == 2)
                        o_sel_b <= 1'b0;
                end
                o_sel_b <= 1'b1;
                o_len   <= n;
                o_done  <= 1'b1;
            end
        end
    end
endmodule : cwg_cpu_model

//--- tb/cwg_wait_gen_bench.sv
// Self-checking bench for the clocked wait state generator
`timescale 1ns/1ps
module cwg_wait_gen_bench;
    localparam int N = 5;
    logic i_clk_sys, i_rst_b, sel_b, wait_b, busy, go, poke, done;
    int   len, err_total, total_checks;
    // ============================================================
    // Instances
    cwg_wait_gen #(.N_STAGES(N)) cwg_wait_gen_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_sel_b(sel_b), .o_wait_b(wait_b), .o_busy(busy));
    cwg_cpu_model cwg_cpu_model_inst (.i_clk_sys(i_clk_sys), .i_go(go), .i_poke(poke),
        .i_wait_b(wait_b), .o_sel_b(sel_b), .o_done(done), .o_len(len));
    // Clock and watchdog
    initial
    begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    initial
    begin
        #(100 * 2000);
        err_total++;
        test_done();
    end
    // ============================================================
    // Compare and helper tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk
    task automatic idle_chk(input string nm);
        chk({nm, " wait_b"}, 1, {31'h0, wait_b});
        chk({nm, " busy"}, 0, {31'h0, busy});
    endtask : idle_chk
    task automatic access(input logic p, input string nm);
        go = 1'b1;
        poke = p;
        @(negedge i_clk_sys);
        go = 1'b0;
        repeat (60)
        begin
            @(negedge i_clk_sys);
            if (done === 1'b1)
                break;
        end
        chk({nm, " length"}, N, len);
        idle_chk(nm);
        $display("%s done", nm);
    endtask : access
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // ============================================================
    // Main sequence
    initial
    begin
        i_rst_b = 1'b0;
        go = 1'b0;
        poke = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        idle_chk("in reset");
        i_rst_b = 1'b1;
        @(negedge i_clk_sys);
        idle_chk("after reset");
        access(1'b0, "single");
        access(1'b0, "back to back");
        access(1'b0, "third");
        access(1'b1, "strobe in hold");
        repeat (10)
        begin
            @(negedge i_clk_sys);
            chk("no extra hold", 0, {31'h0, busy});
        end
        go = 1'b1;
        @(negedge i_clk_sys);
        go = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        i_rst_b = 1'b0;
        @(negedge i_clk_sys);
        idle_chk("mid reset");
        i_rst_b = 1'b1;
        @(negedge i_clk_sys);
        idle_chk("mid reset release");
        $display("reset tests done");
        repeat (45) @(negedge i_clk_sys);
        access(1'b0, "after mid reset");
        test_done();
    end
endmodule : cwg_wait_gen_bench
